/* common/ntl1_pkg.sv */
package ntl1_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int T16_MS = 16;
	localparam int T32_MS = 32;
	localparam int T16_CYC = CLK_HZ / 1000 * T16_MS;
	localparam int T32_CYC = CLK_HZ / 1000 * T32_MS;
	localparam int CONT_HZ = 96_000;
	// alternating pulses: two pulses per period of the 96 kHz pattern
	localparam int CONT_CYC = CLK_HZ / (2 * CONT_HZ);
	localparam int SINGLE_HZ = 2_000;
	localparam int SINGLE_CYC = CLK_HZ / SINGLE_HZ;
	localparam int CI_FIRST = 26;
	localparam int FRAME_BITS = 64;

	localparam logic [3:0] CMD_DEACT = 4'h0;
	localparam logic [3:0] CMD_SINGLE = 4'h2;
	localparam logic [3:0] CMD_RESYNC = 4'h4;
	localparam logic [3:0] CMD_ACT = 4'h8;
	localparam logic [3:0] CMD_ACT_LOOP = 4'hA;
	localparam logic [3:0] CMD_SWITCH = 4'hC;
	localparam logic [3:0] CMD_SWITCH_LOOP = 4'hE;
	localparam logic [3:0] CMD_DEACT_ACK = 4'hF;
	localparam logic [3:0] CMD_RST = 4'hF;

	localparam logic [3:0] IND_CLKREQ = 4'h0;
	localparam logic [3:0] IND_NO_LEVEL = 4'h1;
	localparam logic [3:0] IND_RX_UNSYNC = 4'h4;
	localparam logic [3:0] IND_ERROR = 4'h6;
	localparam logic [3:0] IND_UP_ACT = 4'h8;
	localparam logic [3:0] IND_RX_SYNC = 4'hC;
	localparam logic [3:0] IND_DEACTIVATED = 4'hF;

	localparam logic [2:0] TX_INFO0 = 3'h0;
	localparam logic [2:0] TX_INFO2 = 3'h1;
	localparam logic [2:0] TX_INFO4 = 3'h2;
	localparam logic [2:0] TX_CONT = 3'h3;
	localparam logic [2:0] TX_SINGLE = 3'h4;

	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_IRQ_STAT = 8'h08;
	localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;
	localparam logic [3:0] IRQ_MASK_RST = 4'h0;
	localparam int IRQ_STATE = 0;
	localparam int IRQ_CMD = 1;
	localparam int IRQ_TIMEOUT = 2;
	localparam int IRQ_ERROR = 3;

	typedef enum logic [3:0] {
		ST_DEACT, ST_I1DET, ST_PEND_ACT, ST_SYNCED, ST_ACTIVATED, ST_LOST_FRAMING,
		ST_PEND_DEACT, ST_UNACK, ST_TEST_SINGLE, ST_TEST_CONT
	} ntl1_state_t;
endpackage

/* hdl/ntl1_act.sv */
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - activate sends INFO2; loop variant closes loop2
// - switch-through sends INFO4; loop variant closes loop2
// - deactivate from any state to pending deactivation
// - resync command: lost framing, continuous 96 kHz pulses
// - single-pulse test: alternating pulses every 2 kHz
// - unacknowledged until deactivation acknowledge arrives
// - line activation first reports clock request
// - report no level or receiver unsynchronised
// - reset pin reports error indication
// - INFO1 seen: report upstream activation request
// - INFO1 detected waits for activate command
// - pending activation sends INFO2 until INFO3
// - INFO3 received: INFO2, sync indication, wait
// - activated: INFO4, B and D transparent
// - activated, sync lost: fall back to INFO2
// - pending deactivation ends after 16/32 ms
// - deactivated: line silent, deactivated indication
module ntl1_act
	import ntl1_pkg::*;
#(
	parameter int T16_CYCLES = T16_CYC,
	parameter int T32_CYCLES = T32_CYC,
	parameter int SINGLE_CYCLES = SINGLE_CYC
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic host_bit_clock,
	input wire logic frame_sync,
	input wire logic serial_in,
	output logic serial_out,
	input wire logic line_level,
	input wire logic line_info0,
	input wire logic line_info1,
	input wire logic line_info3,
	input wire logic rx_sync,
	input wire logic rst_pin_n,
	input wire logic continuous_pulse_select,
	output logic [2:0] tx_info,
	output logic tx_pos,
	output logic tx_neg,
	output logic loop2_closed,
	output logic transparent,
	output logic irq
);
	localparam int NSYNC = 10;
	// the reset pin stage comes out of reset at its idle high level, so no false error indication follows nrst
	localparam logic [NSYNC-1:0] SYNC_IDLE = 10'h100;

	// two-stage synchronisers, third stage only for edge finding
	logic [NSYNC-1:0] meta_q, sync_q, sync_d;
	logic dcl_prev_q, fs_prev_q;
	assign sync_d = {continuous_pulse_select, rst_pin_n, rx_sync, line_info3, line_info1,
		line_info0, line_level, serial_in, frame_sync, host_bit_clock};
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			meta_q <= SYNC_IDLE;
			sync_q <= SYNC_IDLE;
			dcl_prev_q <= 1'b0;
			fs_prev_q <= 1'b0;
		end else begin
			meta_q <= sync_d;
			sync_q <= meta_q;
			dcl_prev_q <= sync_q[0];
			fs_prev_q <= sync_q[1];
		end
	end

	logic dcl_rise, dcl_fall, fs_rise, sin_s, lvl_s, i0_s, i1_s, i3_s, rsync_s, rst_act, cps_s;
	assign dcl_rise = sync_q[0] & ~dcl_prev_q;
	assign dcl_fall = ~sync_q[0] & dcl_prev_q;
	assign fs_rise = sync_q[1] & ~fs_prev_q;
	assign sin_s = sync_q[2];
	assign lvl_s = sync_q[3];
	assign i0_s = sync_q[4];
	assign i1_s = sync_q[5];
	assign i3_s = sync_q[6];
	assign rsync_s = sync_q[7];
	assign rst_act = ~sync_q[8];
	assign cps_s = sync_q[9];

	// control/indication channel framing
	logic [5:0] bit_cnt_q, bit_cnt_d;
	logic [3:0] cmd_shift_q, cmd_shift_d, last_cmd_q, last_cmd_d, cmd_code_q, cmd_code_d;
	logic [3:0] ind_q, ind_d, ind_frame_q, ind_frame_d;
	logic cmd_stb_q, cmd_stb_d, sout_q, sout_d;

	function automatic logic in_ci(input logic [5:0] pos);
		in_ci = (pos >= 6'(CI_FIRST)) && (pos < 6'(CI_FIRST + 4));
	endfunction

	always_comb begin
		bit_cnt_d = bit_cnt_q;
		cmd_shift_d = cmd_shift_q;
		last_cmd_d = last_cmd_q;
		cmd_code_d = cmd_code_q;
		ind_frame_d = ind_frame_q;
		cmd_stb_d = 1'b0;
		sout_d = sout_q;
		if (fs_rise) begin
			bit_cnt_d = '0;
			ind_frame_d = ind_q;
			sout_d = 1'b1;
			if (cmd_shift_q != last_cmd_q) begin
				cmd_stb_d = 1'b1;
				cmd_code_d = cmd_shift_q;
				last_cmd_d = cmd_shift_q;
			end
		end else if (dcl_rise) begin
			if (in_ci(bit_cnt_q))
				cmd_shift_d = {cmd_shift_q[2:0], sin_s};
		end else if (dcl_fall) begin
			if (bit_cnt_q != 6'(FRAME_BITS - 1))
				bit_cnt_d = bit_cnt_q + 6'h01;
			if (in_ci(bit_cnt_d))
				sout_d = ind_frame_q[2'(6'(CI_FIRST + 3) - bit_cnt_d)];
			else
				sout_d = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			bit_cnt_q <= '0;
			cmd_shift_q <= CMD_RST;
			last_cmd_q <= CMD_RST;
			cmd_code_q <= CMD_RST;
			ind_frame_q <= IND_DEACTIVATED;
			cmd_stb_q <= 1'b0;
			sout_q <= 1'b1;
		end else begin
			bit_cnt_q <= bit_cnt_d;
			cmd_shift_q <= cmd_shift_d;
			last_cmd_q <= last_cmd_d;
			cmd_code_q <= cmd_code_d;
			ind_frame_q <= ind_frame_d;
			cmd_stb_q <= cmd_stb_d;
			sout_q <= sout_d;
		end
	end

	// layer-1 state machine
	ntl1_state_t state_q, state_d;
	logic [23:0] t32_q, t32_d, i0cnt_q, i0cnt_d;
	logic loop2_q, loop2_d, timeout_ev;
	logic [31:0] ctrl_q;
	logic tx_en;
	assign tx_en = ctrl_q[0];

	always_comb begin
		state_d = state_q;
		loop2_d = loop2_q;
		t32_d = '0;
		i0cnt_d = '0;
		timeout_ev = 1'b0;
		unique case (state_q)
			ST_DEACT: begin
				if (i1_s)
					state_d = ST_I1DET;
			end
			ST_PEND_ACT: begin
				if (i3_s)
					state_d = ST_SYNCED;
			end
			ST_PEND_DEACT: begin
				t32_d = t32_q + 24'h000001;
				i0cnt_d = i0_s ? i0cnt_q + 24'h000001 : 24'h000000;
				if (i0cnt_q == 24'(T16_CYCLES - 1) || t32_q == 24'(T32_CYCLES - 1)) begin
					state_d = ST_UNACK;
					timeout_ev = (t32_q == 24'(T32_CYCLES - 1));
				end
			end
			default: ;
		endcase
		if (cmd_stb_q) begin
			unique case (cmd_code_q)
				CMD_DEACT: begin
					state_d = ST_PEND_DEACT;
					loop2_d = 1'b0;
				end
				CMD_SINGLE: begin
					state_d = ST_TEST_SINGLE;
					loop2_d = 1'b0;
				end
				CMD_RESYNC: begin
					if (state_q != ST_UNACK && state_q != ST_PEND_DEACT)
						state_d = ST_LOST_FRAMING;
				end
				// activation, refused while unacknowledged, leaves INFO1 wait
				CMD_ACT, CMD_ACT_LOOP: begin
					if (state_q inside {ST_DEACT, ST_I1DET, ST_LOST_FRAMING}) begin
						state_d = ST_PEND_ACT;
						loop2_d = (cmd_code_q == CMD_ACT_LOOP);
					end
				end
				CMD_SWITCH, CMD_SWITCH_LOOP: begin
					if (state_q inside {ST_SYNCED, ST_LOST_FRAMING, ST_ACTIVATED}) begin
						state_d = ST_ACTIVATED;
						loop2_d = (cmd_code_q == CMD_SWITCH_LOOP);
					end
				end
				CMD_DEACT_ACK: begin
					if (state_q == ST_UNACK)
						state_d = ST_DEACT;
				end
				default: ;
			endcase
		end
		// continuous pulses by pin; reset pin overrides everything
		if (cps_s) begin
			state_d = ST_TEST_CONT;
			loop2_d = 1'b0;
		end else if (state_q == ST_TEST_CONT) begin
			state_d = ST_DEACT;
		end
		if (rst_act) begin
			state_d = ST_DEACT;
			loop2_d = 1'b0;
		end
	end

	// outputs derived from the next state so they line up with state_q
	logic [2:0] tx_info_q, tx_info_d;
	logic transp_q, transp_d;
	always_comb begin
		tx_info_d = TX_INFO0;
		transp_d = 1'b0;
		ind_d = lvl_s ? IND_RX_UNSYNC : IND_NO_LEVEL;
		unique case (state_d)
			ST_DEACT: begin
				if (lvl_s)
					ind_d = IND_CLKREQ;
				else
					ind_d = IND_DEACTIVATED;
			end
			ST_I1DET: ind_d = IND_UP_ACT;
			ST_PEND_ACT: tx_info_d = TX_INFO2;
			ST_SYNCED: begin
				tx_info_d = TX_INFO2;
				ind_d = IND_RX_SYNC;
			end
			ST_ACTIVATED: begin
				tx_info_d = rsync_s ? TX_INFO4 : TX_INFO2;
				transp_d = rsync_s;
				if (rsync_s)
					ind_d = IND_RX_SYNC;
			end
			ST_LOST_FRAMING: tx_info_d = TX_CONT;
			ST_PEND_DEACT: tx_info_d = TX_INFO0;
			ST_UNACK: ind_d = IND_DEACTIVATED;
			ST_TEST_SINGLE: tx_info_d = TX_SINGLE;
			ST_TEST_CONT: tx_info_d = TX_CONT;
			default: ;
		endcase
		if (rst_act)
			ind_d = IND_ERROR;
		// software can hold the line quiet
		if (!tx_en)
			tx_info_d = TX_INFO0;
	end

	// pulse pattern generator for the test and resync modes
	logic [13:0] pcnt_q, pcnt_d;
	logic pol_q, pol_d, pos_q, pos_d, neg_q, neg_d;
	logic [13:0] pspan;
	always_comb begin
		pspan = (tx_info_d == TX_SINGLE) ? 14'(SINGLE_CYCLES - 1) : 14'(CONT_CYC - 1);
		pcnt_d = pcnt_q;
		pol_d = pol_q;
		pos_d = 1'b0;
		neg_d = 1'b0;
		if (tx_info_d == TX_CONT || tx_info_d == TX_SINGLE) begin
			if (pcnt_q >= pspan) begin
				pcnt_d = '0;
				pol_d = ~pol_q;
			end else begin
				pcnt_d = pcnt_q + 14'h0001;
			end
			// each mark lasts one pulse slot, then polarity flips
			pos_d = (pcnt_d < 14'(CONT_CYC)) & pol_d;
			neg_d = (pcnt_d < 14'(CONT_CYC)) & ~pol_d;
		end else begin
			pcnt_d = '0;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_DEACT;
			loop2_q <= 1'b0;
			t32_q <= '0;
			i0cnt_q <= '0;
			tx_info_q <= TX_INFO0;
			transp_q <= 1'b0;
			ind_q <= IND_DEACTIVATED;
			pcnt_q <= '0;
			pol_q <= 1'b0;
			pos_q <= 1'b0;
			neg_q <= 1'b0;
		end else begin
			state_q <= state_d;
			loop2_q <= loop2_d;
			t32_q <= t32_d;
			i0cnt_q <= i0cnt_d;
			tx_info_q <= tx_info_d;
			transp_q <= transp_d;
			ind_q <= ind_d;
			pcnt_q <= pcnt_d;
			pol_q <= pol_d;
			pos_q <= pos_d;
			neg_q <= neg_d;
		end
	end

	// APB slave: one wait state, read data taken at the edge that raises pready, writes at the edge pready is seen
	logic [31:0] ctrl_d, prdata_q, prdata_d;
	logic [3:0] ista_q, ista_d, imask_q, imask_d, ev;
	logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d, acc, wr;
	assign acc = psel & penable & pready_q;
	assign wr = acc & pwrite;
	assign ev = {rst_act & (ind_q != IND_ERROR), timeout_ev, cmd_stb_q, state_d != state_q};

	always_comb begin
		pready_d = psel & penable & ~pready_q;
		pslverr_d = 1'b0;
		prdata_d = prdata_q;
		ctrl_d = ctrl_q;
		imask_d = imask_q;
		ista_d = ista_q;
		if (pready_d) begin
			prdata_d = '0;
			unique case (paddr)
				REG_CTRL: prdata_d = ctrl_q;
				REG_STATUS: prdata_d = {16'h0000, last_cmd_q, ind_q, 4'h0, 4'(state_q)};
				REG_IRQ_STAT: prdata_d = {28'h0000000, ista_q};
				REG_IRQ_MASK: prdata_d = {28'h0000000, imask_q};
				default: pslverr_d = 1'b1;
			endcase
		end
		if (wr && paddr == REG_CTRL)
			ctrl_d = {31'h00000000, pwdata[0]};
		if (wr && paddr == REG_IRQ_MASK)
			imask_d = pwdata[3:0];
		if (wr && paddr == REG_IRQ_STAT)
			ista_d = ista_q & ~pwdata[3:0];
		// a new event wins over a same-cycle clear
		ista_d = ista_d | ev;
		irq_d = |(ista_d & imask_d);
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q <= CTRL_RST;
			imask_q <= IRQ_MASK_RST;
			ista_q <= '0;
			prdata_q <= '0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			imask_q <= imask_d;
			ista_q <= ista_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			irq_q <= irq_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq = irq_q;
	assign serial_out = sout_q;
	assign tx_info = tx_info_q;
	assign tx_pos = pos_q;
	assign tx_neg = neg_q;
	assign loop2_closed = loop2_q;
	assign transparent = transp_q;

	logic tx_pos_q_or_neg;
	assign tx_pos_q_or_neg = pos_q | neg_q;

	sequence s_plain_cmd(logic [3:0] c);
		cmd_stb_q && cmd_code_q == c && !rst_act && !cps_s;
	endsequence
	sequence s_single_run;
		state_q == ST_TEST_SINGLE && $past(tx_en);
	endsequence

	AST_DEACT_ANY: assert property (@(posedge mclk) disable iff (!nrst)
		s_plain_cmd(CMD_DEACT) |=> state_q == ST_PEND_DEACT)
		else $error("deactivate command did not reach pending deactivation");
	AST_ACT_INFO2: assert property (@(posedge mclk) disable iff (!nrst)
		s_plain_cmd(CMD_ACT_LOOP) ##1 state_q == ST_PEND_ACT |-> loop2_q && (tx_info_q == TX_INFO2 || !$past(tx_en)))
		else $error("loop activation without INFO2 and loop");
	AST_SWITCH_INFO4: assert property (@(posedge mclk) disable iff (!nrst)
		state_q == ST_ACTIVATED && $past(rsync_s) && $past(tx_en) |-> tx_info_q == TX_INFO4)
		else $error("activated with sync but not sending INFO4");
	AST_FALLBACK: assert property (@(posedge mclk) disable iff (!nrst)
		state_q == ST_ACTIVATED && !$past(rsync_s) |-> tx_info_q != TX_INFO4 && !transp_q)
		else $error("INFO4 kept after sync loss");
	AST_SINGLE: assert property (@(posedge mclk) disable iff (!nrst)
		s_plain_cmd(CMD_SINGLE) ##1 s_single_run |-> tx_info_q == TX_SINGLE)
		else $error("single pulse test not transmitting");
	AST_RESYNC: assert property (@(posedge mclk) disable iff (!nrst)
		state_q == ST_LOST_FRAMING && tx_en |-> ##[1:300] (tx_pos_q_or_neg))
		else $error("no pulses in lost framing");
	AST_UNACK_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
		(state_q == ST_UNACK) and s_plain_cmd(CMD_ACT) |=> state_q == ST_UNACK)
		else $error("activation accepted while unacknowledged");
	AST_ERROR_IND: assert property (@(posedge mclk) disable iff (!nrst)
		rst_act |=> ind_q == IND_ERROR && state_q == ST_DEACT)
		else $error("reset pin not answered by error indication");
	AST_I1_IND: assert property (@(posedge mclk) disable iff (!nrst)
		state_q == ST_I1DET && !$past(rst_act) |-> ind_q == IND_UP_ACT)
		else $error("INFO1 state without activation request indication");
	AST_PEND_DEACT_END: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(state_q == ST_UNACK) |-> $past(i0cnt_q) == 24'(T16_CYCLES - 1) || $past(t32_q) == 24'(T32_CYCLES - 1))
		else $error("left pending deactivation at wrong time");
	AST_QUIET: assert property (@(posedge mclk) disable iff (!nrst)
		state_q == ST_UNACK && !$past(rst_act) |-> tx_info_q == TX_INFO0 && ind_q == IND_DEACTIVATED)
		else $error("deactivated state not silent");
	AST_CHANGE_ONLY: assert property (@(posedge mclk) disable iff (!nrst)
		fs_rise && cmd_shift_q == last_cmd_q |=> !cmd_stb_q)
		else $error("repeated code acted upon");
endmodule

/* tb/ntl1_upstream.sv */
`timescale 1ns/1ps
module ntl1_upstream
	import ntl1_pkg::*;
(
	output logic host_bit_clock,
	output logic frame_sync,
	output logic serial_in,
	input wire logic serial_out,
	input wire logic run,
	input wire logic [3:0] cmd,
	output logic [3:0] ind,
	output int frames
);
	logic [3:0] ind_sh;
	logic ci;
	logic [3:0] cur;
	initial begin
		host_bit_clock = 1'b0;
		frame_sync = 1'b0;
		serial_in = 1'b1;
		ind = 4'hF;
		ind_sh = 4'hF;
		frames = 0;
		wait (run);
		forever begin
			// code taken whole at frame start, so a change mid-frame never mixes two codes
			cur = cmd;
			for (int i = 0; i < FRAME_BITS; i++) begin
				ci = (i >= CI_FIRST) && (i < CI_FIRST + 4);
				// code sent every frame
				// pull-up level outside the command bits
				serial_in = ci ? cur[3 - (i - CI_FIRST)] : 1'b1;
				#100;
				host_bit_clock = 1'b1;
				frame_sync = (i == 0);
				#200;
				if (ci) begin
					ind_sh = {ind_sh[2:0], serial_out};
				end
				host_bit_clock = 1'b0;
				frame_sync = 1'b0;
				#100;
			end
			ind = ind_sh;
			frames++;
		end
	end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top
	import ntl1_pkg::*;
;
	localparam int T16 = 1000;
	localparam int T32 = 3000;
	localparam int SGL = 400;
	logic mclk, nrst, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic err, bclk, fsync, sin, sout, lvl, i0, i1, i3, rxs, rstp_n, cps, run;
	logic [2:0] tx_info;
	logic tx_pos, tx_neg, loop2, transp;
	logic [3:0] cmd, ind;
	int frames, num_errors, check_count;

	ntl1_act #(.T16_CYCLES(T16), .T32_CYCLES(T32), .SINGLE_CYCLES(SGL)) uut (.mclk(mclk), .nrst(nrst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .host_bit_clock(bclk), .frame_sync(fsync), .serial_in(sin),
		.serial_out(sout), .line_level(lvl), .line_info0(i0), .line_info1(i1), .line_info3(i3),
		.rx_sync(rxs), .rst_pin_n(rstp_n), .continuous_pulse_select(cps), .tx_info(tx_info),
		.tx_pos(tx_pos), .tx_neg(tx_neg), .loop2_closed(loop2), .transparent(transp), .irq(irq));
	ntl1_upstream up (.host_bit_clock(bclk), .frame_sync(fsync), .serial_in(sin), .serial_out(sout),
		.run(run), .cmd(cmd), .ind(ind), .frames(frames));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		apb(1'b0, a, 32'h0);
		check(nm, exp, rd & m);
	endtask

	task automatic fwait(input int n);
		int f;
		f = frames;
		wait (frames >= f + n);
		@(posedge mclk);
	endtask

	task automatic send(input logic [3:0] c);
		cmd <= c;
		fwait(3);
	endtask

	task automatic chk_st(input ntl1_state_t s, input logic [2:0] t);
		rdchk("state", REG_STATUS, 32'(s), 32'h0000_000F);
		check("tx_info", 32'(t), 32'(tx_info));
	endtask

	task automatic gap(input int exp);
		int n;
		n = 0;
		while (tx_pos === 1'b1 && n < 30000) begin
			@(posedge mclk);
			n++;
		end
		while (tx_pos !== 1'b1 && n < 30000) begin
			@(posedge mclk);
			n++;
		end
		n = 0;
		while (tx_neg !== 1'b1 && n < 30000) begin
			@(posedge mclk);
			n++;
		end
		check("pulse gap", 32'(exp), 32'(n));
	endtask

	// the run should need about 34k cycles
	initial begin
		#4_500_000;
		num_errors++;
		report_and_stop();
	end

	initial begin
		{nrst, psel, penable, pwrite, lvl, i0, i1, i3, rxs, cps, run} = '0;
		paddr = 8'h00;
		pwdata = 32'h0;
		rstp_n = 1'b1;
		cmd = 4'hF;
		repeat (6) @(posedge mclk);
		nrst <= 1'b1;
		run <= 1'b1;
		rdchk("ctrl", REG_CTRL, CTRL_RST, 32'hFFFF_FFFF);
		rdchk("mask", REG_IRQ_MASK, 32'(IRQ_MASK_RST), 32'h0000_000F);
		rdchk("unmapped", 8'h10, 32'h0, 32'hFFFF_FFFF);
		check("pslverr", 32'h1, 32'(err));
		fwait(3);
		check("ind", 32'(IND_DEACTIVATED), 32'(ind));
		chk_st(ST_DEACT, TX_INFO0);
		lvl <= 1'b1;
		fwait(3);
		check("ind", 32'(IND_CLKREQ), 32'(ind));
		i1 <= 1'b1;
		fwait(3);
		check("ind", 32'(IND_UP_ACT), 32'(ind));
		chk_st(ST_I1DET, TX_INFO0);
		send(CMD_ACT);
		chk_st(ST_PEND_ACT, TX_INFO2);
		check("loop2", 32'h0, 32'(loop2));
		i1 <= 1'b0;
		i3 <= 1'b1;
		rxs <= 1'b1;
		fwait(3);
		chk_st(ST_SYNCED, TX_INFO2);
		check("ind", 32'(IND_RX_SYNC), 32'(ind));
		send(CMD_SWITCH);
		chk_st(ST_ACTIVATED, TX_INFO4);
		check("transparent", 32'h1, 32'(transp));
		rxs <= 1'b0;
		fwait(3);
		check("tx_info", 32'(TX_INFO2), 32'(tx_info));
		check("ind", 32'(IND_RX_UNSYNC), 32'(ind));
		rxs <= 1'b1;
		fwait(3);
		send(CMD_SWITCH_LOOP);
		chk_st(ST_ACTIVATED, TX_INFO4);
		check("loop2", 32'h1, 32'(loop2));
		i3 <= 1'b0;
		send(CMD_DEACT);
		chk_st(ST_PEND_DEACT, TX_INFO0);
		fwait(7);
		chk_st(ST_UNACK, TX_INFO0);
		check("ind", 32'(IND_DEACTIVATED), 32'(ind));
		rdchk("timeout irq", REG_IRQ_STAT, 32'h4, 32'h4);
		send(CMD_ACT);
		chk_st(ST_UNACK, TX_INFO0);
		send(CMD_DEACT_ACK);
		chk_st(ST_DEACT, TX_INFO0);
		send(CMD_ACT_LOOP);
		chk_st(ST_PEND_ACT, TX_INFO2);
		check("loop2", 32'h1, 32'(loop2));
		// info0 seen: the short timer must win over the long one
		apb(1'b1, REG_IRQ_STAT, 32'h4);
		i0 <= 1'b1;
		send(CMD_DEACT);
		fwait(3);
		chk_st(ST_UNACK, TX_INFO0);
		rdchk("no timeout irq", REG_IRQ_STAT, 32'h0, 32'h4);
		send(CMD_DEACT_ACK);
		i0 <= 1'b0;
		lvl <= 1'b0;
		send(CMD_RESYNC);
		chk_st(ST_LOST_FRAMING, TX_CONT);
		gap(CONT_CYC);
		fwait(1);
		check("ind", 32'(IND_NO_LEVEL), 32'(ind));
		apb(1'b1, REG_CTRL, 32'h0);
		repeat (4) @(posedge mclk);
		check("tx off", 32'(TX_INFO0), 32'(tx_info));
		apb(1'b1, REG_CTRL, 32'h1);
		send(CMD_SINGLE);
		chk_st(ST_TEST_SINGLE, TX_SINGLE);
		gap(SGL);
		cps <= 1'b1;
		repeat (10) @(posedge mclk);
		chk_st(ST_TEST_CONT, TX_CONT);
		rstp_n <= 1'b0;
		fwait(3);
		chk_st(ST_DEACT, TX_INFO0);
		check("ind", 32'(IND_ERROR), 32'(ind));
		rdchk("reset irq", REG_IRQ_STAT, 32'h8, 32'h8);
		// a mask bit of one lets its status bit through
		check("irq masked", 32'h0, 32'(irq));
		apb(1'b1, REG_IRQ_MASK, 32'hF);
		@(posedge mclk);
		check("irq on", 32'h1, 32'(irq));
		apb(1'b1, REG_IRQ_STAT, 32'hF);
		rdchk("irq clear", REG_IRQ_STAT, 32'h0, 32'hF);
		check("irq cleared", 32'h0, 32'(irq));
		apb(1'b1, REG_IRQ_MASK, 32'h0);
		@(posedge mclk);
		check("irq idle", 32'h0, 32'(irq));
		report_and_stop();
	end
endmodule
